//--- design/ffp_pipeline.sv
// Purpose: Phase generator, prefetch and execute sequencing of a small 8-bit core.
// Assumes: Oscillator ticks are one-cycle enables synchronous to I_CORE_CLK.
// Notes:   Program memory answers combinationally while O_PM_RD is high.
`timescale 1ns/1ps
`include "ffp_params.svh"

module ffp_pipeline
(
    input  wire logic                  I_CORE_CLK,
    input  wire logic                  I_NRST,
    input  wire logic [3:0]            I_OSC_TICK,
    input  wire ffp_pkg::ffp_clk_src_t I_CLK_SEL,
    output logic [3:0]                 O_PHASE_CLOCKS,
    output logic                       O_CYCLE_END,
    output logic                       O_PM_RD,
    output ffp_pkg::ffp_pc_t           O_PM_ADDR,
    input  wire logic [15:0]           I_PM_DATA,
    output ffp_pkg::ffp_dm_req_t       O_DM_REQ,
    input  wire ffp_pkg::ffp_byte_t    I_DM_RDATA,
    output ffp_pkg::ffp_byte_t         O_ACC,
    output logic                       O_STACK_PUSH,
    output ffp_pkg::ffp_pc_t           O_RET_ADDR
);
    import ffp_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    ffp_phase_t  phase_r,    phase_nxt;
    ffp_pc_t     pc_r,       pc_nxt;
    ffp_insn_t   fetch_ir_r, fetch_ir_nxt;
    logic        fetch_v_r,  fetch_v_nxt;
    ffp_insn_t   exec_ir_r,  exec_ir_nxt;
    logic        exec_v_r,   exec_v_nxt;
    logic        ext_r,      ext_nxt;
    ffp_byte_t   acc_r,      acc_nxt;
    ffp_byte_t   ptr_r,      ptr_nxt;
    ffp_byte_t   opnd_r,     opnd_nxt;
    ffp_dm_req_t dm_r,       dm_nxt;
    logic        push_r,     push_nxt;
    ffp_pc_t     ret_r,      ret_nxt;

    logic        tick;
    logic        redirect;
    ffp_byte_t   maddr;
    ffp_byte_t   ea;
    ffp_byte_t   rd_val;
    ffp_byte_t   alu_res;

    // ------------------------------------------------------------------------
    // ALU
    // ------------------------------------------------------------------------
    function automatic ffp_byte_t ffp_alu(input logic [2:0] fn, input ffp_byte_t a, input ffp_byte_t b);
        case (fn)
            3'h0:    ffp_alu = a + b;
            3'h1:    ffp_alu = a - b;
            3'h2:    ffp_alu = a & b;
            3'h3:    ffp_alu = a | b;
            3'h4:    ffp_alu = a ^ b;
            3'h5:    ffp_alu = {b[0], b[7:1]};
            3'h6:    ffp_alu = b + 8'h01;
            3'h7:    ffp_alu = b - 8'h01;
            default: ffp_alu = a;
        endcase
    endfunction

    assign tick           = I_OSC_TICK[I_CLK_SEL];
    assign O_PHASE_CLOCKS = 4'h1 << phase_r;
    assign O_CYCLE_END    = tick && (phase_r == ph_t4);
    assign O_PM_RD        = (phase_r == ph_t1) && !ext_r;
    assign O_PM_ADDR      = pc_r;
    assign O_DM_REQ       = dm_r;
    assign O_ACC          = acc_r;
    assign O_STACK_PUSH   = push_r;
    assign O_RET_ADDR     = ret_r;

    // Indirect access goes through the pointer register, as any other core register would.
    assign maddr   = exec_ir_r.body[`FFP_MADDR_HI:0];
    assign ea      = (maddr == `FFP_ADDR_IND) ? ptr_r : maddr;
    assign alu_res = ffp_alu(exec_ir_r.body[`FFP_FN_HI:`FFP_FN_LO], acc_r, opnd_r);

    always_comb
    begin
        case (ea)
            `FFP_ADDR_ACC: rd_val = acc_r;
            `FFP_ADDR_PC_LOW_BYTE: rd_val = pc_r[`FFP_MADDR_HI:0];
            `FFP_ADDR_PTR: rd_val = ptr_r;
            default:       rd_val = I_DM_RDATA;
        endcase
    end

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always_comb
    begin
        phase_nxt    = phase_r;
        pc_nxt       = pc_r;
        fetch_ir_nxt = fetch_ir_r;
        fetch_v_nxt  = fetch_v_r;
        exec_ir_nxt  = exec_ir_r;
        exec_v_nxt   = exec_v_r;
        ext_nxt      = ext_r;
        acc_nxt      = acc_r;
        ptr_nxt      = ptr_r;
        opnd_nxt     = opnd_r;
        dm_nxt       = dm_r;
        dm_nxt.we    = 1'b0;
        push_nxt     = 1'b0;
        ret_nxt      = ret_r;
        redirect     = 1'b0;
        if (tick)
        begin
            phase_nxt = ffp_phase_t'(phase_r + 2'b01);
            case (phase_r)
                ph_t1:
                begin
                    // The second cycle of an extended instruction must not fetch again.
                    if (!ext_r)
                    begin
                        fetch_ir_nxt = ffp_insn_t'(I_PM_DATA);
                        fetch_v_nxt  = 1'b1;
                        pc_nxt       = pc_r + 13'h0001;
                    end
                    dm_nxt.addr = ea;
                end
                ph_t2:
                begin
                    dm_nxt.addr = ea;
                end
                ph_t3:
                begin
                    opnd_nxt = rd_val;
                end
                ph_t4:
                begin
                    if (exec_v_r)
                    begin
                        case (exec_ir_r.op)
                            op_alu:
                            begin
                                acc_nxt = alu_res;
                            end
                            op_alu_ext:
                            begin
                                if (ext_r)
                                begin
                                    acc_nxt = alu_res;
                                end
                                ext_nxt = !ext_r;
                            end
                            op_jump:
                            begin
                                pc_nxt   = exec_ir_r.body;
                                redirect = 1'b1;
                            end
                            op_call:
                            begin
                                pc_nxt   = exec_ir_r.body;
                                ret_nxt  = pc_r - 13'h0001;
                                push_nxt = 1'b1;
                                redirect = 1'b1;
                            end
                            op_skip_z:
                            begin
                                redirect = (opnd_r == `FFP_BYTE_RST);
                            end
                            op_store:
                            begin
                                dm_nxt.addr  = ea;
                                dm_nxt.wdata = acc_r;
                                dm_nxt.we    = (ea != `FFP_ADDR_PC_LOW_BYTE) && (ea != `FFP_ADDR_PTR) &&
                                               (ea != `FFP_ADDR_ACC);
                                if (ea == `FFP_ADDR_PTR)
                                begin
                                    ptr_nxt = acc_r;
                                end
                                if (ea == `FFP_ADDR_PC_LOW_BYTE)
                                begin
                                    pc_nxt   = {pc_r[`FFP_PAGE_HI:`FFP_PAGE_LO], acc_r};
                                    redirect = 1'b1;
                                end
                            end
                            default:
                            begin
                            end
                        endcase
                    end
                    // A held extended instruction keeps both stages; otherwise the prefetch moves on.
                    if (!(exec_v_r && (exec_ir_r.op == op_alu_ext) && !ext_r))
                    begin
                        exec_ir_nxt = fetch_ir_r;
                        exec_v_nxt  = fetch_v_r && !redirect;
                        fetch_v_nxt = 1'b0;
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_NRST)
        begin
            phase_r    <= ph_t1;
            pc_r       <= `FFP_PC_RST;
            fetch_ir_r <= ffp_insn_t'(`FFP_WORD_RST);
            fetch_v_r  <= 1'b0;
            exec_ir_r  <= ffp_insn_t'(`FFP_WORD_RST);
            exec_v_r   <= 1'b0;
            ext_r      <= 1'b0;
            acc_r      <= `FFP_BYTE_RST;
            ptr_r      <= `FFP_BYTE_RST;
            opnd_r     <= `FFP_BYTE_RST;
            dm_r       <= '0;
            push_r     <= 1'b0;
            ret_r      <= `FFP_PC_RST;
        end
        else
        begin
            phase_r    <= phase_nxt;
            pc_r       <= pc_nxt;
            fetch_ir_r <= fetch_ir_nxt;
            fetch_v_r  <= fetch_v_nxt;
            exec_ir_r  <= exec_ir_nxt;
            exec_v_r   <= exec_v_nxt;
            ext_r      <= ext_nxt;
            acc_r      <= acc_nxt;
            ptr_r      <= ptr_nxt;
            opnd_r     <= opnd_nxt;
            dm_r       <= dm_nxt;
            push_r     <= push_nxt;
            ret_r      <= ret_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    phase_onehot_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
        $onehot(O_PHASE_CLOCKS)) else $error("phase clocks overlap");
    src_select_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
        !I_OSC_TICK[I_CLK_SEL] |=> $stable(phase_r)) else $error("phase moved without selected tick");
    cycle_wrap_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
        O_CYCLE_END |=> phase_r == ph_t1) else $error("cycle did not wrap to first phase");
    pc_step_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
        (O_PM_RD && tick) |=> (pc_r == $past(pc_r) + 13'h0001) && fetch_v_r) else $error("no step on fetch");
    dm_write_late_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
        O_DM_REQ.we |-> $past(phase_r) == ph_t4) else $error("data write outside last phase");
    branch_flush_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
        (O_CYCLE_END && redirect) |=> !exec_v_r && !fetch_v_r) else $error("prefetch survived redirect");
    ext_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
        (O_CYCLE_END && exec_v_r && exec_ir_r.op == op_alu_ext && !ext_r) |=> ext_r && $stable(acc_r))
        else $error("extended instruction did not hold");
    call_push_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
        O_STACK_PUSH |-> (O_RET_ADDR == $past(pc_r) - 13'h0001) && !exec_v_r) else $error("bad call push");
    pc_low_page_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
        (O_CYCLE_END && exec_v_r && exec_ir_r.op == op_store && ea == `FFP_ADDR_PC_LOW_BYTE)
        |=> pc_r == {$past(pc_r[12:8]), $past(acc_r)}) else $error("low byte write left page");
    reset_empty_a: assert property (@(posedge I_CORE_CLK)
        !I_NRST |=> !exec_v_r && !fetch_v_r) else $error("pipeline valid after reset");

endmodule

//--- design/ffp_params.svh
// Purpose: Constants of the four phase fetch and execute pipeline.
// Assumes: Included by its bare name from the pipeline module only; the package does not include it.
// Notes:   Addresses are data memory locations that the core maps onto its own registers.
`ifndef FFP_PARAMS_SVH
`define FFP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Mapped core registers in data memory
// ----------------------------------------------------------------------------
`define FFP_ADDR_IND              8'h00
`define FFP_ADDR_PTR              8'h01
`define FFP_ADDR_ACC              8'h05
`define FFP_ADDR_PC_LOW_BYTE      8'h06

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FFP_PC_RST        13'h0000
`define FFP_BYTE_RST      8'h00
`define FFP_WORD_RST      16'h0000

// ----------------------------------------------------------------------------
// Instruction and program counter page field positions
// ----------------------------------------------------------------------------
`define FFP_FN_HI         12
`define FFP_FN_LO         10
`define FFP_MADDR_HI      7
`define FFP_PAGE_HI       12
`define FFP_PAGE_LO       8

`endif

//--- design/ffp_pkg.sv
// Purpose: Types of the four phase fetch and execute pipeline.
// Assumes: Nothing; it uses no constant of the header.
// Notes:   The instruction encoding is a reduced one for this sequencer only.
package ffp_pkg;

    typedef logic [12:0] ffp_pc_t;
    typedef logic [7:0]  ffp_byte_t;

    typedef enum logic [1:0]
    {
        ph_t1 = 2'b00,
        ph_t2 = 2'b01,
        ph_t3 = 2'b10,
        ph_t4 = 2'b11
    } ffp_phase_t;

    typedef enum logic [1:0]
    {
        ext_high_speed_crystal = 2'b00,
        ext_low_speed_crystal  = 2'b01,
        int_high_speed_rc      = 2'b10,
        int_low_speed_rc       = 2'b11
    } ffp_clk_src_t;

    typedef enum logic [2:0]
    {
        op_alu      = 3'b000,
        op_alu_ext  = 3'b001,
        op_jump     = 3'b010,
        op_call     = 3'b011,
        op_skip_z   = 3'b100,
        op_store    = 3'b101,
        op_nop      = 3'b110
    } ffp_op_t;

    typedef struct packed
    {
        ffp_op_t     op;
        logic [12:0] body;
    } ffp_insn_t;

    typedef struct packed
    {
        ffp_byte_t addr;
        ffp_byte_t wdata;
        logic      we;
    } ffp_dm_req_t;

endpackage

//--- dv/ffp_prog_mem.sv
// Purpose: Program memory model that answers fetches of the pipeline.
// Assumes: The bench loads mem before a run; reads are combinational.
// Notes:   While not read the data lines carry a toggling junk pattern.
`timescale 1ns/1ps

module ffp_prog_mem
(
    input  wire logic             i_clk,
    input  wire logic             i_rd,
    input  wire ffp_pkg::ffp_pc_t i_addr,
    output logic [15:0]           o_data
);
    import ffp_pkg::*;

    // --------------------
    // Storage and output
    // --------------------
    logic [15:0] mem [256];
    logic [15:0] junk_r = 16'h5a5a;

    // Junk toggles so that a fetch outside the read window cannot match.
    always_ff @(posedge i_clk)
        junk_r <= ~junk_r;

    assign o_data = i_rd ? mem[i_addr[7:0]] : junk_r;
endmodule

//--- dv/four_phase_fetch_execute_pipeline_tb.sv
// Purpose: Self-checking bench of the pipeline against an instruction-level model.
// Assumes: Program and data memory contents come from the bench random source.
// Notes:   Each fetch is compared on address and accumulator.
`timescale 1ns/1ps

module four_phase_fetch_execute_pipeline_tb;
    import ffp_pkg::*;

    // --------------------
    // Signals and model state
    // --------------------
    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    logic [3:0]   tick_v = 4'h0;
    ffp_clk_src_t sel = ext_high_speed_crystal;
    logic [3:0]   phs;
    logic         cyc_end, pm_rd, push, tick;
    ffp_pc_t      pm_addr, ret_addr;
    logic [15:0]  pm_data;
    ffp_dm_req_t  dm_req;
    ffp_byte_t    dm_rdata = 8'h00;
    ffp_byte_t    acc;
    logic [31:0]  seed = 32'h3593ad9b;
    logic [7:0]   hw_dm [256];
    int           m_dm [256];
    int           n_mismatch = 0, n_compared = 0, cycles = 0, ph = 0, run_on = 0, fast = 0;
    int           q_addr[$], q_acc[$], q_wa[$], q_wd[$], q_ret[$];

    ffp_pipeline ffp_pipeline_inst (.I_CORE_CLK(clk), .I_NRST(nrst), .I_OSC_TICK(tick_v), .I_CLK_SEL(sel),
        .O_PHASE_CLOCKS(phs), .O_CYCLE_END(cyc_end), .O_PM_RD(pm_rd), .O_PM_ADDR(pm_addr),
        .I_PM_DATA(pm_data), .O_DM_REQ(dm_req), .I_DM_RDATA(dm_rdata), .O_ACC(acc),
        .O_STACK_PUSH(push), .O_RET_ADDR(ret_addr));
    ffp_prog_mem ffp_prog_mem_inst (.i_clk(clk), .i_rd(pm_rd), .i_addr(pm_addr), .o_data(pm_data));

    initial
        forever #20 clk = ~clk;

    // --------------------
    // Helpers
    // --------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
    endfunction

    function automatic int alu(input int fn, input int a, input int m);
        case (fn)
            0: return (a + m) & 255;
            1: return (a - m) & 255;
            2: return a & m;
            3: return a | m;
            4: return a ^ m;
            5: return ((m & 1) << 7) | (m >> 1);
            6: return (m + 1) & 255;
            default: return (m - 1) & 255;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Operands sit in 10..1f or go through the pointer; stores may also hit the pointer, the accumulator
    // or the low counter byte.
    task automatic build();
        logic [7:0] m;
        for (int i = 0; i < 256; i++)
        begin
            seed = lfsr(seed);
            m = 8'h10 | seed[23:20];
            if (seed[11:10] == 2'b00)
                m = 8'h00;
            if (seed[2:0] == 3'd5 && seed[9:8] < 2)
                m = seed[8] ? 8'h06 : 8'h05;
            else if (seed[2:0] == 3'd5 && seed[9:8] == 2'd2)
                m = 8'h01;
            if (seed[2:1] == 2'b01)
                ffp_prog_mem_inst.mem[i] = {seed[2:0], 5'h00, seed[19:12]};
            else
                ffp_prog_mem_inst.mem[i] = {seed[2:0], seed[6:4], 2'b00, m};
            hw_dm[i] = seed[31] ? 8'h00 : seed[31:24];
            m_dm[i] = hw_dm[i];
        end
    endtask

    // A taken branch queues the flushed fetch and then the dummy-cycle fetch of the target.
    task automatic model_run(input int n);
        logic [15:0] w;
        int pc, a, m, t, cnt, p, e, v;
        w = ffp_prog_mem_inst.mem[0];
        q_addr.push_back(0);
        q_acc.push_back(0);
        pc = 1;
        a = 0;
        p = 0;
        cnt = 1;
        while (cnt < n)
        begin
            m = w[7:0];
            // Address 0 goes through the pointer; mapped core registers read back their own value.
            e = (m == 0) ? p : m;
            v = (e == 5) ? a : (e == 6) ? ((pc + 1) & 255) : (e == 1) ? p : m_dm[e];
            t = -1;
            q_addr.push_back(pc);
            q_acc.push_back(a);
            cnt++;
            case (w[15:13])
                3'd0, 3'd1: a = alu(w[12:10], a, v);
                3'd2: t = w[12:0];
                3'd3: begin t = w[12:0]; q_ret.push_back(pc); end
                3'd4: if (v == 0) t = (pc + 1) & 'h1fff;
                3'd5: if (e == 6) t = ((pc + 1) & 'h1f00) | a;
                      else if (e == 1) p = a;
                      else if (e != 5) begin m_dm[e] = a; q_wa.push_back(e); q_wd.push_back(a); end
                default: ;
            endcase
            if (t >= 0)
            begin
                q_addr.push_back(t);
                q_acc.push_back(a);
                cnt++;
                pc = t;
            end
            w = ffp_prog_mem_inst.mem[pc & 255];
            pc = (pc + 1) & 'h1fff;
        end
    endtask

    // --------------------
    // Drivers and monitors
    // --------------------
    always @(negedge clk)
    begin
        seed = lfsr(seed);
        tick_v <= fast ? 4'hf : seed[3:0];
        dm_rdata <= hw_dm[dm_req.addr];
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 30000)
        begin
            n_mismatch++;
            $display("Error at %0t: run did not finish", $time);
            finish_test();
        end
        if (dm_req.we)
            hw_dm[dm_req.addr] <= dm_req.wdata;
        if (run_on)
        begin
            tick = tick_v[sel];
            check(phs, 4'h1 << ph, "phase");
            check(cyc_end, tick && ph == 3, "cycle end");
            if (tick)
                ph = (ph + 1) % 4;
            if (tick && phs[0] && pm_rd && q_addr.size() > 0)
            begin
                check(pm_addr, q_addr.pop_front(), "fetch address");
                check(acc, q_acc.pop_front(), "accumulator");
            end
            if (dm_req.we && q_wa.size() == 0)
                check(1, 0, "unexpected write");
            else if (dm_req.we)
                check({dm_req.addr, dm_req.wdata}, {8'(q_wa.pop_front()), 8'(q_wd.pop_front())}, "write");
            if (push && q_ret.size() == 0)
                check(1, 0, "unexpected push");
            else if (push)
                check(ret_addr, q_ret.pop_front(), "return address");
        end
    end

    // --------------------
    // Main sequence: one run per clock source
    // --------------------
    initial
    begin
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clk);
            build();
            @(negedge clk);
            sel = ffp_clk_src_t'(s);
            fast = (s == 0);
            nrst = 1'b0;
            ph = 0;
            repeat (6) @(negedge clk);
            nrst = 1'b1;
            check({phs, pm_rd, push, dm_req.we, acc}, {4'h1, 3'b100, 8'h00}, "reset state");
            check(pm_addr, 0, "reset address");
            model_run(60);
            run_on = 1;
            while (q_addr.size() != 0)
                @(posedge clk);
            @(posedge clk iff cyc_end);
            @(posedge clk);
            @(negedge clk);
            run_on = 0;
            check(q_wa.size() + q_ret.size(), 0, "missing writes or pushes");
            q_wa.delete();
            q_wd.delete();
            q_ret.delete();
            $display("Test with clock source %0d done", s);
        end
        finish_test();
    end
endmodule
